// File: logic/emam_addr_mux.sv
// address generation and clock outputs of the external memory interface
`timescale 1ns/1ps
module emam_addr_mux (
  // clocks and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic sdram_clock_in,
  output logic system_clock_out,
  output logic sdram_if_clk_o,
  // column width settings
  input wire logic colw_wr_i,
  input wire logic [1:0] colw_bank_i,
  input wire logic [1:0] colw_val_i,
  // access request
  input wire logic req_i,
  input wire logic [emam_pkg::IADDR_W-1:0] iaddr_i,
  input wire logic [1:0] tgt_i,
  input wire logic [1:0] width_i,
  input wire logic [1:0] sd_bank_i,
  input wire logic col_step_i,
  input wire logic done_i,
  output logic busy_o,
  output logic row_phase_o,
  output logic col_phase_o,
  // address pins
  output logic addr_bit21_or_bank_bit1,
  output logic addr_bit20_or_bank_bit0,
  output logic [19:0] addr_o
);
  // ********************************************************
  // clocks
  // ********************************************************
  // pass-through only; a real chip would use a clock buffer here
  assign system_clock_out = mclk_i;
  assign sdram_if_clk_o = sdram_clock_in;

  // ********************************************************
  // helpers
  // ********************************************************
  // memory word address from byte address, per access width
  function automatic logic [emam_pkg::IADDR_W-1:0] word_addr(
    input logic [emam_pkg::IADDR_W-1:0] a, input logic [1:0] w);
    logic [emam_pkg::IADDR_W-1:0] r;
    r = a;
    if (w == emam_pkg::EMAM_W16) begin
      r = a >> 1;
    end else if (w == emam_pkg::EMAM_W32) begin
      r = a >> 2;
    end
    return r;
  endfunction

  // column part, masked to the programmed width
  function automatic logic [emam_pkg::SD_ADDR_W-1:0] col_part(
    input logic [emam_pkg::IADDR_W-1:0] a, input logic [1:0] cw);
    logic [emam_pkg::IADDR_W-1:0] m;
    m = (32'h00000100 << cw) - 32'h00000001;
    return emam_pkg::SD_ADDR_W'(a & m);
  endfunction

  // row part, word address above the programmed column bits
  function automatic logic [emam_pkg::SD_ADDR_W-1:0] row_part(
    input logic [emam_pkg::IADDR_W-1:0] a, input logic [1:0] cw);
    logic [emam_pkg::IADDR_W-1:0] s;
    s = a >> (emam_pkg::COL_MIN_BITS + int'(cw));
    return emam_pkg::SD_ADDR_W'(s);
  endfunction

  // sdram pin image: bank on top, unused bits 19:13 held low
  function automatic logic [emam_pkg::ADDR_W-1:0] sd_pins(
    input logic [1:0] bk, input logic [emam_pkg::SD_ADDR_W-1:0] part);
    return {bk, 7'h00, part};
  endfunction

  // target decode, shared by the state machine and the address latch
  function automatic logic is_sdram(input logic [1:0] t);
    return t == emam_pkg::EMAM_TGT_SDRAM;
  endfunction

  function automatic logic is_io(input logic [1:0] t);
    return t == emam_pkg::EMAM_TGT_IO;
  endfunction

  // ********************************************************
  // column width memory
  // ********************************************************
  logic [1:0] colw;
  emam_colw_regs u_colw (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(colw_wr_i),
    .wr_bank_i(colw_bank_i),
    .wr_colw_i(colw_val_i),
    .rd_bank_i(sd_bank_i),
    .rd_colw_o(colw)
  );

  // ********************************************************
  // state and address registers
  // ********************************************************
  emam_pkg::emam_state_e state_q, state_d;
  logic [emam_pkg::IADDR_W-1:0] wa_q, wa_d;
  logic [1:0] bank_q, bank_d;
  logic [emam_pkg::ADDR_W-1:0] pins_q, pins_d;

  // ********************************************************
  // request decode
  // ********************************************************
  logic take_req;
  logic take_sd;
  logic [emam_pkg::IADDR_W-1:0] wa_new;
  logic [emam_pkg::ADDR_W-1:0] async_pins;

  // requests only taken while idle; a stray one while busy is dropped
  assign take_req = req_i && (state_q == emam_pkg::EMAM_IDLE);
  assign take_sd = take_req && is_sdram(tgt_i);
  assign wa_new = word_addr(iaddr_i, width_i);
  // io targets see the raw byte address, the board picks its lines
  assign async_pins = is_io(tgt_i) ? iaddr_i[emam_pkg::ADDR_W-1:0]
    : wa_new[emam_pkg::ADDR_W-1:0];

  // ********************************************************
  // phase state machine
  // ********************************************************
  // col_step_i outside the row phase and done_i while idle are ignored
  always_comb begin
    state_d = state_q;
    case (state_q)
      emam_pkg::EMAM_IDLE: begin
        if (take_req) begin
          if (is_sdram(tgt_i)) begin
            state_d = emam_pkg::EMAM_ROW;
          end else begin
            state_d = emam_pkg::EMAM_ASYNC;
          end
        end
      end
      emam_pkg::EMAM_ROW: begin
        if (col_step_i) begin
          state_d = emam_pkg::EMAM_COL;
        end
      end
      emam_pkg::EMAM_COL: begin
        if (done_i) begin
          state_d = emam_pkg::EMAM_IDLE;
        end
      end
      emam_pkg::EMAM_ASYNC: begin
        if (done_i) begin
          state_d = emam_pkg::EMAM_IDLE;
        end
      end
      default: begin
        // illegal code falls back to idle rather than locking up
        state_d = emam_pkg::EMAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= emam_pkg::EMAM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ********************************************************
  // address latch and pin image
  // ********************************************************
  // pins refresh every row/column cycle, so a late width write still lands;
  // the width read follows sd_bank_i, which must hold through the cycle
  always_comb begin
    wa_d = wa_q;
    bank_d = bank_q;
    pins_d = pins_q;
    if (take_sd) begin
      wa_d = wa_new;
      bank_d = sd_bank_i;
    end else if (take_req) begin
      pins_d = async_pins;
    end else if (state_q == emam_pkg::EMAM_ROW) begin
      // column width read is registered on the same edge as bank capture
      pins_d = sd_pins(bank_q, row_part(wa_q, colw));
    end else if (state_q == emam_pkg::EMAM_COL) begin
      pins_d = sd_pins(bank_q, col_part(wa_q, colw));
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wa_q <= '0;
      bank_q <= 2'h0;
      pins_q <= emam_pkg::ADDR_RST;
    end else begin
      wa_q <= wa_d;
      bank_q <= bank_d;
      pins_q <= pins_d;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign busy_o = state_q != emam_pkg::EMAM_IDLE;
  assign row_phase_o = state_q == emam_pkg::EMAM_ROW;
  assign col_phase_o = state_q == emam_pkg::EMAM_COL;
  assign addr_bit21_or_bank_bit1 = pins_q[21];
  assign addr_bit20_or_bank_bit0 = pins_q[20];
  assign addr_o = pins_q[19:0];
endmodule

// File: logic/emam_colw_regs.sv
// per-bank sdram column width settings
`timescale 1ns/1ps
module emam_colw_regs (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // write port
  input wire logic wr_i,
  input wire logic [1:0] wr_bank_i,
  input wire logic [1:0] wr_colw_i,
  // read port
  input wire logic [1:0] rd_bank_i,
  output logic [1:0] rd_colw_o
);
  logic [1:0] colw_q [emam_pkg::BANKS];
  logic [1:0] colw_d [emam_pkg::BANKS];
  logic [1:0] rd_q;
  logic [1:0] rd_d;

  always_comb begin
    for (int i = 0; i < emam_pkg::BANKS; i++) begin
      colw_d[i] = colw_q[i];
    end
    if (wr_i) begin
      colw_d[wr_bank_i] = wr_colw_i;
    end
    rd_d = colw_d[rd_bank_i];
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < emam_pkg::BANKS; i++) begin
        colw_q[i] <= emam_pkg::COLW_RST;
      end
      rd_q <= emam_pkg::COLW_RST;
    end else begin
      colw_q <= colw_d;
      rd_q <= rd_d;
    end
  end

  assign rd_colw_o = rd_q;
endmodule

// File: logic/emam_pkg.sv
// constants and types for the external memory address mux
//
// Notes on behaviour
// - internal system clock is driven out and clocks the sdram interface
// - sdram controller takes its interface clock from the sdram clock input
// - top two address outputs carry addr 21:20 async, bank bits on sdram
// - one 22-bit address bus covers 4M space for all bank kinds
// - sdram cycles split internal address into row and column addresses
// - column width programmable per bank, 8 to 11 bits; split follows it
// - sdram cycles: low 13 outputs carry row/column, top two carry bank
// - non-sdram cycles put 22 address bits on the outputs: word address for rom, raw byte address for io
// - sdram and rom/flash/sram addresses shifted for 8/16/32-bit width
package emam_pkg;
  // ********************************************************
  // widths and counts
  // ********************************************************
  localparam int ADDR_W = 22;
  localparam int IADDR_W = 32;
  localparam int SD_ADDR_W = 13;
  localparam int BANKS = 4;
  localparam logic [1:0] COL_MIN_SEL = 2'h0;
  localparam int COL_MIN_BITS = 8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
  localparam logic [1:0] COLW_RST = 2'h0;

  // access width, selects the byte-address shift
  typedef enum logic [1:0] {
    EMAM_W8 = 2'h0,
    EMAM_W16 = 2'h1,
    EMAM_W32 = 2'h2
  } emam_width_e;

  // kind of target for the cycle
  typedef enum logic [1:0] {
    EMAM_TGT_ROM = 2'h0,
    EMAM_TGT_SDRAM = 2'h1,
    EMAM_TGT_IO = 2'h2
  } emam_tgt_e;

  // address phase states
  typedef enum logic [3:0] {
    EMAM_IDLE = 4'h1,
    EMAM_ROW = 4'h2,
    EMAM_COL = 4'h4,
    EMAM_ASYNC = 4'h8
  } emam_state_e;
endpackage

// File: test/emam_addr_mux_asserts.sv
// checker for the address mux
`timescale 1ns/1ps
module emam_addr_mux_asserts (
  input wire logic mclk_i, sys_rst_i, sdram_clock_in, system_clock_out,
  input wire logic sdram_if_clk_o, req_i, col_step_i, done_i, busy_o,
  input wire logic row_phase_o, col_phase_o,
  input wire logic addr_bit21_or_bank_bit1, addr_bit20_or_bank_bit0,
  input wire logic [1:0] tgt_i, sd_bank_i,
  input wire logic [19:0] addr_o,
  input wire logic [31:0] iaddr_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire go = req_i && !busy_o;
  wire [19:0] ia = iaddr_i[19:0];
  wire [1:0] bk = {addr_bit21_or_bank_bit1, addr_bit20_or_bank_bit0};
  property p_clk; system_clock_out == mclk_i; endproperty
  a_clk: assert property (p_clk) else $error("clk out");
  property p_sdc; sdram_if_clk_o == sdram_clock_in; endproperty
  a_sdc: assert property (p_sdc) else $error("sd clk");
  property p_row; go && tgt_i == 2'h1 |=> row_phase_o; endproperty
  a_row: assert property (p_row) else $error("row");
  property p_col; row_phase_o && col_step_i |=> col_phase_o && !row_phase_o; endproperty
  a_col: assert property (p_col) else $error("col");
  property p_hi; row_phase_o |=> addr_o[19:13] == 7'h0; endproperty
  a_hi: assert property (p_hi) else $error("hi");
  property p_bank; row_phase_o |=> bk == $past(sd_bank_i); endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_io; go && tgt_i == 2'h2 |=> addr_o == $past(ia); endproperty
  a_io: assert property (p_io) else $error("io");
  property p_done; col_phase_o && done_i |=> !busy_o; endproperty
  a_done: assert property (p_done) else $error("done");
  c_rc: cover property (row_phase_o ##1 col_phase_o);
  c_io: cover property (go && tgt_i == 2'h2);
  c_end: cover property (busy_o ##1 !busy_o);
endmodule

// File: test/emam_mem_model.sv
// board side model: clock loop
`timescale 1ns/1ps
module emam_mem_model (
  input wire logic system_clock_out,
  output logic sdram_clock_in
);
  // trace returns clock out as sdram clock
  assign sdram_clock_in = system_clock_out;
  // io parts take unshifted byte lines
endmodule

// File: test/external_memory_address_mux_bench.sv
// bench for the address mux
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
module external_memory_address_mux_bench;
  typedef struct {logic [1:0] t, w, b, c; logic [31:0] a; logic [21:0] r, k;} emam_row_s;
  int miscompares = 0;
  int num_checks = 0;
  logic mclk_i = 0, sys_rst_i = 1, req_i = 0, col_step_i = 0, done_i = 0, colw_wr_i = 0;
  logic [1:0] tgt_i = 0, width_i = 0, sd_bank_i = 0, colw_bank_i = 0, colw_val_i = 0;
  logic [31:0] iaddr_i = 0;
  wire sdram_clock_in, system_clock_out, sdram_if_clk_o, busy_o, row_phase_o, col_phase_o;
  wire addr_bit21_or_bank_bit1, addr_bit20_or_bank_bit0;
  wire [19:0] addr_o;
  wire [21:0] pins = {addr_bit21_or_bank_bit1, addr_bit20_or_bank_bit0, addr_o};
  // type, width, bank, colw, address, row pins, final pins
  emam_row_s rows [8] = '{
    '{2'h0, 2'h0, 2'h0, 2'h0, 32'h00123456, 22'h0, 22'h123456},
    '{2'h0, 2'h1, 2'h0, 2'h0, 32'h002468AC, 22'h0, 22'h123456},
    '{2'h0, 2'h2, 2'h0, 2'h0, 32'h0048D158, 22'h0, 22'h123456},
    '{2'h2, 2'h2, 2'h0, 2'h0, 32'h00123457, 22'h0, 22'h123457},
    '{2'h1, 2'h0, 2'h2, 2'h0, 32'h00123456, 22'h201234, 22'h200056},
    '{2'h1, 2'h2, 2'h3, 2'h3, 32'h00801FFC, 22'h300400, 22'h3007FF},
    '{2'h1, 2'h1, 2'h1, 2'h1, 32'h00000A02, 22'h100002, 22'h100101},
    '{2'h1, 2'h0, 2'h0, 2'h2, 32'h00000C01, 22'h000003, 22'h000001}};
  emam_addr_mux uut (.*);
  emam_mem_model mdl (.*);
  initial forever #2.5 mclk_i = ~mclk_i;
  task automatic run(input emam_row_s r);
    @(negedge mclk_i);
    colw_wr_i = 1;
    colw_bank_i = r.b;
    colw_val_i = r.c;
    @(negedge mclk_i);
    colw_wr_i = 0;
    req_i = 1;
    tgt_i = r.t;
    width_i = r.w;
    sd_bank_i = r.b;
    iaddr_i = r.a;
    @(negedge mclk_i);
    req_i = 0;
    if (r.t == 2'h1) begin
      // stray request while busy must be ignored
      @(negedge mclk_i);
      col_step_i = 1;
      req_i = 1;
      @(negedge mclk_i);
      col_step_i = 0;
      req_i = 0;
      `CHK(pins, r.r)
      `CHK(col_phase_o, 1'b1)
      `CHK(row_phase_o, 1'b0)
      repeat (2) @(negedge mclk_i);
    end
    `CHK(pins, r.k)
    done_i = 1;
    @(negedge mclk_i);
    done_i = 0;
    `CHK(busy_o, 1'b0)
  endtask
  task report_and_stop;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 0;
    `CHK(pins, 22'h0)
    #1;
    `CHK(system_clock_out, mclk_i)
    `CHK(sdram_if_clk_o, mclk_i)
    foreach (rows[i]) begin
      run(rows[i]);
      $display("test %0d done", i);
    end
    // reset in mid cycle clears pins
    req_i = 1;
    tgt_i = 2'h1;
    @(negedge mclk_i);
    req_i = 0;
    repeat (2) @(negedge mclk_i);
    sys_rst_i = 1;
    @(negedge mclk_i);
    `CHK(pins, 22'h0)
    `CHK(busy_o, 1'b0)
    sys_rst_i = 0;
    run(rows[5]);
    $display("test reset done");
    report_and_stop;
  end
  initial begin
    #20000;
    miscompares++;
    report_and_stop;
  end
endmodule
bind emam_addr_mux emam_addr_mux_asserts chk (.*);
